// File: usart_async_receiver.sv
// asynchronous serial receiver: start-bit recovery, majority voting, parity
// and frame checks, overrun tracking and a two-entry receive buffer.
// assumes sample_tick is a one-cycle pulse on mclk at 16x (8x in double speed)
// the baud rate, and data_read_strobe marks a software read of the data.
`timescale 1ns/1ps

`include "usart_rx_defines.svh"

// Operation
// R01: with nine-bit frames software reads the ninth bit before the data byte.
// R02: a data read pops the buffer; ninth bit and errors follow next frame.
// R03: receive-complete flag is one exactly while unread frames are buffered.
// R04: clearing receiver enable flushes buffer and drops receive-complete flag.
// R05: interrupt request follows receive-complete flag while its enable is set.
// R06: frame, overrun and parity errors are buffered with their own frame.
// R07: status writes never change the three error flags; software writes zeros.
// R08: none of the error flags drives any interrupt request.
// R09: frame error is one when the first stop bit voted low.
// R10: only the first stop bit is checked; stop-bit count is ignored.
// R11: overrun when buffer full, character waiting, and new start bit found.
// R12: overrun indication clears once a frame moves into the buffer.
// R13: parity error reads zero whenever parity checking is disabled.
// R14: parity checker runs when enable bit set; compares data parity with bit.
// R15: parity result stays with its frame until that frame is read.
// R16: disabling stops reception at once, empties buffer, releases the pin.
// R17: software empties the buffer by reading data until flag reads zero.
// R18: line sampled at sixteen times baud, eight times in double speed.
// R19: start qualified by samples 8,9,10 or 4,5,6 after first low sample.
// R20: two or more high qualifying samples reject start; else synchronise.
// R21: every data, parity and stop bit decided by centre three-sample vote.
// R22: while enabled the receiver takes over the receive pin.
// R23: odd-select low checks even parity, high checks odd parity.
module usart_async_receiver (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic serial_rx_pin,
    input wire logic rx_enable,
    input wire logic rx_complete_irq_enable,
    input wire logic double_speed_select,
    input wire logic parity_enable_bit,
    input wire logic parity_odd_select,
    input wire logic stop_bit_count_select,
    input wire logic [2:0] char_size_select,
    input wire logic data_read_strobe,
    output logic [7:0] serial_data_reg,
    output logic rx_ninth_bit,
    output logic frame_error_flag,
    output logic overrun_flag,
    output logic parity_error_flag,
    output logic rx_complete_flag,
    output logic rx_complete_irq,
    output logic rx_pin_override
);

    // -----------------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------------
    function automatic logic [4:0] samples_per_bit(input logic dbl);
        samples_per_bit = dbl ? `RX_OS_DOUBLE : `RX_OS_NORMAL;
    endfunction

    function automatic logic [4:0] vote_first(input logic dbl);
        vote_first = dbl ? `RX_VOTE_DOUBLE : `RX_VOTE_NORMAL;
    endfunction

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // codes 0..3 give five to eight bits, 7 gives nine; others fall back to eight
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        case (code)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            3'h7: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    // -----------------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------------
    logic rx_meta_q;
    logic rx_sync_q;
    logic line_prev_q;
    usart_rx_pkg::rx_state_e state_q;
    logic [4:0] cnt_q;
    logic [1:0] votes_q;
    logic [3:0] bit_idx_q;
    logic [8:0] shift_q;
    logic par_bit_q;
    logic hold_valid_q;
    usart_rx_pkg::rx_entry_t hold_q;
    logic dor_pending_q;

    logic tick;
    logic [4:0] os_len;
    logic [4:0] vote_pos;
    logic [3:0] n_bits;
    logic vote_now;
    logic bit_end;
    logic bit_val;
    logic start_ok;
    logic start_reject;
    logic frame_done;
    logic overrun_evt;
    logic par_err;
    usart_rx_pkg::rx_entry_t new_entry;
    usart_rx_pkg::rx_entry_t push_entry;
    logic fifo_wr_valid;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic pushed;
    usart_rx_pkg::rx_entry_t head;

    // -----------------------------------------------------------------------
    // pin synchroniser
    // -----------------------------------------------------------------------
    // idle-high reset so a held-off line never looks like a start edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= `RX_SYNC_RESET;
            rx_sync_q <= `RX_SYNC_RESET;
        end else if (clk_en) begin
            rx_meta_q <= serial_rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // -----------------------------------------------------------------------
    // sampling and voting
    // -----------------------------------------------------------------------
    assign rx_pin_override = rx_enable; // [R22]
    assign tick = clk_en && sample_tick && rx_enable;
    assign os_len = samples_per_bit(double_speed_select); // [R18]
    assign vote_pos = vote_first(double_speed_select);
    assign n_bits = data_bits(char_size_select);
    assign vote_now = tick && (state_q != usart_rx_pkg::ST_IDLE) && (cnt_q == vote_pos + 5'h02); // [R19] [R21]
    assign bit_end = tick && (cnt_q == os_len);
    assign bit_val = maj3(votes_q[1], votes_q[0], rx_sync_q); // [R21]
    assign start_ok = vote_now && (state_q == usart_rx_pkg::ST_START) && !bit_val; // [R20]
    assign start_reject = vote_now && (state_q == usart_rx_pkg::ST_START) && bit_val; // [R20]
    // only the first stop bit is voted; a second one is just idle line [R10]
    assign frame_done = vote_now && (state_q == usart_rx_pkg::ST_STOP);

    // even: data xor parity bit is zero; odd: it is one [R14] [R23]
    assign par_err = parity_enable_bit && ((^shift_q) ^ par_bit_q ^ parity_odd_select);
    always_comb begin
        new_entry = '0;
        new_entry[`RX_DATA_W-1:0] = shift_q;
        new_entry[`RX_FE_POS] = !bit_val; // [R09]
        new_entry[`RX_PE_POS] = par_err; // [R15]
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            line_prev_q <= `RX_PREV_RESET;
        end else if (clk_en) begin
            if (!rx_enable) begin
                line_prev_q <= `RX_PREV_RESET;
            end else if (tick) begin
                line_prev_q <= rx_sync_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            votes_q <= 2'h0;
        end else if (tick) begin
            if (cnt_q == vote_pos) begin
                votes_q[1] <= rx_sync_q;
            end
            if (cnt_q == vote_pos + 5'h01) begin
                votes_q[0] <= rx_sync_q;
            end
        end
    end

    // -----------------------------------------------------------------------
    // frame state machine
    // -----------------------------------------------------------------------
    // disable acts at once: a half-received frame is simply dropped [R16]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= usart_rx_pkg::ST_IDLE;
            cnt_q <= 5'h00;
            bit_idx_q <= 4'h0;
        end else if (clk_en) begin
            if (!rx_enable) begin
                state_q <= usart_rx_pkg::ST_IDLE;
                cnt_q <= 5'h00;
                bit_idx_q <= 4'h0;
            end else if (tick) begin
                cnt_q <= (cnt_q == os_len) ? 5'h01 : cnt_q + 5'h01; // [R18]
                case (state_q)
                    usart_rx_pkg::ST_IDLE: begin
                        cnt_q <= 5'h01;
                        if (line_prev_q && !rx_sync_q) begin
                            // edge tick is sample 1, so the next tick must count as 2
                            cnt_q <= 5'h02; // [R19]
                            state_q <= usart_rx_pkg::ST_START; // [R19]
                        end
                    end
                    usart_rx_pkg::ST_START: begin
                        if (start_reject) begin
                            state_q <= usart_rx_pkg::ST_IDLE; // [R20]
                        end else if (bit_end) begin
                            state_q <= usart_rx_pkg::ST_DATA;
                            bit_idx_q <= 4'h0;
                        end
                    end
                    usart_rx_pkg::ST_DATA: begin
                        if (bit_end) begin
                            if (bit_idx_q == n_bits - 4'h1) begin
                                state_q <= parity_enable_bit ? usart_rx_pkg::ST_PARITY : usart_rx_pkg::ST_STOP;
                            end else begin
                                bit_idx_q <= bit_idx_q + 4'h1;
                            end
                        end
                    end
                    usart_rx_pkg::ST_PARITY: begin
                        if (bit_end) begin
                            state_q <= usart_rx_pkg::ST_STOP;
                        end
                    end
                    usart_rx_pkg::ST_STOP: begin
                        // next start edge may follow the last vote sample directly
                        if (frame_done) begin
                            state_q <= usart_rx_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= usart_rx_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // unused upper bits stay zero, so short characters read masked
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 9'h000;
            par_bit_q <= 1'b0;
        end else if (tick) begin
            if (state_q == usart_rx_pkg::ST_IDLE) begin
                shift_q <= 9'h000;
            end else if (vote_now && state_q == usart_rx_pkg::ST_DATA) begin
                shift_q[bit_idx_q] <= bit_val; // [R21]
            end else if (vote_now && state_q == usart_rx_pkg::ST_PARITY) begin
                par_bit_q <= bit_val;
            end
        end
    end

    // -----------------------------------------------------------------------
    // shift-register hold and overrun
    // -----------------------------------------------------------------------
    // a held character is lost only on disable or when the next start bit needs the shifter
    assign overrun_evt = start_ok && hold_valid_q && !fifo_wr_ready; // [R11]
    assign fifo_wr_valid = rx_enable && (hold_valid_q || frame_done);
    assign pushed = clk_en && fifo_wr_valid && fifo_wr_ready;

    always_comb begin
        push_entry = hold_valid_q ? hold_q : new_entry;
        push_entry[`RX_DOR_POS] = dor_pending_q; // [R06]
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_valid_q <= 1'b0;
            hold_q <= '0;
        end else if (clk_en) begin
            if (!rx_enable || overrun_evt) begin
                hold_valid_q <= 1'b0;
            end else if (frame_done && (hold_valid_q || !fifo_wr_ready)) begin
                hold_valid_q <= 1'b1;
                hold_q <= new_entry;
            end else if (pushed) begin
                hold_valid_q <= 1'b0;
            end
        end
    end

    // set wins over the clear from a successful move
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dor_pending_q <= 1'b0;
        end else if (clk_en) begin
            if (!rx_enable) begin
                dor_pending_q <= 1'b0;
            end else if (overrun_evt) begin
                dor_pending_q <= 1'b1; // [R11]
            end else if (pushed) begin
                dor_pending_q <= 1'b0; // [R12]
            end
        end
    end

    // -----------------------------------------------------------------------
    // receive buffer and software view
    // -----------------------------------------------------------------------
    rx_fifo u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .flush(!rx_enable), // [R04] [R16]
        .wr_valid(fifo_wr_valid),
        .wr_ready(fifo_wr_ready),
        .wr_data(push_entry),
        .rd_pop(data_read_strobe), // [R02]
        .rd_valid(fifo_rd_valid),
        .rd_data(head)
    );

    // error flags come from the head entry, parity also masked by parity_enable_bit, so no write path can touch them [R07]
    assign rx_complete_flag = fifo_rd_valid; // [R03]
    assign serial_data_reg = fifo_rd_valid ? head[7:0] : 8'h00;
    assign rx_ninth_bit = fifo_rd_valid && head[8];
    assign frame_error_flag = fifo_rd_valid && head[`RX_FE_POS];
    assign overrun_flag = fifo_rd_valid && head[`RX_DOR_POS];
    assign parity_error_flag = fifo_rd_valid && parity_enable_bit && head[`RX_PE_POS]; // [R13] [R15]
    assign rx_complete_irq = rx_complete_flag && rx_complete_irq_enable; // [R05] [R08]

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_flush_empties: assert property ((clk_en && !rx_enable) |=> !rx_complete_flag) // [R04]
        else $error("receive flag set after disable");
    a_irq_holds: assert property ((rx_complete_irq && !data_read_strobe && rx_enable) ##1 // [R05]
        rx_complete_irq_enable |-> rx_complete_irq)
        else $error("interrupt dropped while frames remain");
    a_irq_no_errors: assert property (rx_complete_irq |-> rx_complete_flag) // [R08]
        else $error("interrupt without receive-complete flag");
    a_parity_off: assert property (!parity_enable_bit |-> !parity_error_flag) // [R13]
        else $error("parity error shown with checking disabled");
    a_frame_error: assert property ((frame_done && !hold_valid_q && !fifo_rd_valid && clk_en) // [R09]
        |=> (frame_error_flag == !$past(bit_val)))
        else $error("frame error does not match stop bit vote");
    a_overrun_set: assert property ((clk_en && overrun_evt) |=> dor_pending_q) // [R11]
        else $error("overrun not recorded");
    a_overrun_clear: assert property ((pushed && rx_enable && !overrun_evt) |=> !dor_pending_q) // [R12]
        else $error("overrun not cleared after move");
    a_start_qual: assert property (start_ok |-> // [R19]
        (cnt_q == (double_speed_select ? 5'h06 : 5'h0A)))
        else $error("start qualified at wrong sample");
    a_start_reject: assert property (start_reject |=> (state_q == usart_rx_pkg::ST_IDLE)) // [R20]
        else $error("noisy start bit not rejected");
    a_tick_wrap: assert property ((tick && state_q != usart_rx_pkg::ST_IDLE && cnt_q == os_len) // [R18]
        |=> (cnt_q == 5'h01))
        else $error("sample counter did not wrap at bit length");

    c_start_rejected: cover property (start_reject);
    c_frame_stored: cover property (pushed && !hold_valid_q);
    c_overrun: cover property (overrun_evt);
    c_nine_bit_read: cover property (data_read_strobe && rx_ninth_bit);

endmodule

// File: usart_rx_defines.svh
// constants for the asynchronous serial receiver: buffer depth, entry layout,
// oversampling counts and voting positions.
// assumes it is included by bare name from the package and the design modules.
`ifndef USART_RX_DEFINES_SVH
`define USART_RX_DEFINES_SVH

// ---------------------------------------------------------------------------
// receive buffer
// ---------------------------------------------------------------------------
`define RX_FIFO_DEPTH 2
`define RX_DATA_W 9
`define RX_ENTRY_W 12
`define RX_FE_POS 9
`define RX_PE_POS 10
`define RX_DOR_POS 11

// ---------------------------------------------------------------------------
// oversampling
// ---------------------------------------------------------------------------
`define RX_OS_NORMAL 5'h10
`define RX_OS_DOUBLE 5'h08
`define RX_VOTE_NORMAL 5'h08
`define RX_VOTE_DOUBLE 5'h04

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RX_SYNC_RESET 1'b1
`define RX_PREV_RESET 1'b0

`endif

// File: usart_rx_pkg.sv
// types shared by the receiver and its receive buffer.
// assumes usart_rx_defines.svh is on the include path.
package usart_rx_pkg;

`include "usart_rx_defines.svh"

    // -----------------------------------------------------------------------
    // types
    // -----------------------------------------------------------------------
    typedef logic [`RX_ENTRY_W-1:0] rx_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } rx_state_e;

endpackage

// File: rx_fifo.sv
// two-entry receive buffer holding frame data with its error status.
// assumes one clock, one clock enable and a synchronous flush from the receiver.
`timescale 1ns/1ps

`include "usart_rx_defines.svh"

module rx_fifo (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire usart_rx_pkg::rx_entry_t wr_data,
    input wire logic rd_pop,
    output logic rd_valid,
    output usart_rx_pkg::rx_entry_t rd_data
);

    // -----------------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------------
    usart_rx_pkg::rx_entry_t mem_q [0:`RX_FIFO_DEPTH-1];
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;
    usart_rx_pkg::rx_entry_t next_head;

    function automatic logic next_ptr(input logic p);
        next_ptr = ~p;
    endfunction

    assign wr_ready = (count_q != 2'h2);
    assign rd_valid = (count_q != 2'h0);
    assign push = clk_en && !flush && wr_valid && wr_ready;
    assign pop = clk_en && !flush && rd_pop && rd_valid;
    assign rd_data = mem_q[rd_ptr_q];
    assign next_head = mem_q[next_ptr(rd_ptr_q)];

    // error bits travel in the same word as the data [R06]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `RX_FIFO_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push) begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    // a read moves the head to the next frame; flush drops everything [R02] [R04]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else if (clk_en) begin
            if (flush) begin
                rd_ptr_q <= 1'b0;
                wr_ptr_q <= 1'b0;
                count_q <= 2'h0;
            end else begin
                if (push) begin
                    wr_ptr_q <= next_ptr(wr_ptr_q);
                end
                if (pop) begin
                    rd_ptr_q <= next_ptr(rd_ptr_q);
                end
                count_q <= count_q + {1'b0, push} - {1'b0, pop};
            end
        end
    end

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    a_pop_advance: assert property (@(posedge mclk) disable iff (!rst_n) // [R02]
        (pop && count_q == 2'h2) |=> (rd_data == $past(next_head)))
        else $error("head did not advance on read");
    a_flush_clears: assert property (@(posedge mclk) disable iff (!rst_n) // [R04]
        (clk_en && flush) |=> !rd_valid)
        else $error("buffer not empty after flush");
    a_entry_kept: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
        (push && count_q == 2'h0 && !pop) |=> (rd_data == $past(wr_data)))
        else $error("stored entry differs from written entry");

endmodule

// File: serial_tx_model.sv
// remote serial transmitter model driving the receive line.
// assumes sample_tick pulses for one mclk cycle at the oversampling rate.
`timescale 1ns/1ps

module serial_tx_model (
    output logic line,
    input wire logic mclk,
    input wire logic sample_tick
);
    // -----------------------------------------------------------------------
    // line driver
    // -----------------------------------------------------------------------
    initial line = 1'b1; // idle high, as a pulled-up line rests

    // holds a level for a number of ticks, then moves just after the edge
    task automatic hold(input logic v, input int ticks);
        line = v;
        repeat (ticks) begin
            @(posedge mclk);
            while (sample_tick !== 1'b1) @(posedge mclk);
        end
        #1;
    endtask

    // lsb first; parity and stop level chosen by caller so errors can be made
    task automatic send(input logic [8:0] d, input int nb, input logic par_on, input logic par,
                        input logic stop, input int spb);
        hold(1'b0, spb);
        for (int i = 0; i < nb; i++) hold(d[i], spb);
        if (par_on) hold(par, spb);
        hold(stop, spb);
        hold(1'b1, spb);
    endtask
endmodule

// File: usart_async_receiver_tb.sv
// self-checking bench for the asynchronous receiver.
// assumes the design files and serial_tx_model are compiled first.
`timescale 1ns/1ps

module usart_async_receiver_tb;
    logic mclk, rst_n, clk_en, sample_tick, line, rx_enable, irq_en, ds, pen, podd, sbs, rd;
    logic [2:0] csz;
    logic [7:0] data;
    logic ninth, fe, dor, pe, rxc, irq, ovr;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [2:0] sz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    wire logic [11:0] head = {dor, pe, fe, ninth, data};

    serial_tx_model m (.line(line), .mclk(mclk), .sample_tick(sample_tick));
    usart_async_receiver dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .sample_tick(sample_tick),
        .serial_rx_pin(line), .rx_enable(rx_enable), .rx_complete_irq_enable(irq_en),
        .double_speed_select(ds), .parity_enable_bit(pen), .parity_odd_select(podd),
        .stop_bit_count_select(sbs), .char_size_select(csz), .data_read_strobe(rd),
        .serial_data_reg(data), .rx_ninth_bit(ninth), .frame_error_flag(fe), .overrun_flag(dor),
        .parity_error_flag(pe), .rx_complete_flag(rxc), .rx_complete_irq(irq), .rx_pin_override(ovr));

    // -----------------------------------------------------------------------
    // clock, tick and timeout
    // -----------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial sample_tick = 1'b0;
    // tick every other cycle keeps frames short
    always @(posedge mclk) sample_tick <= #1 ~sample_tick;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    // -----------------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // only pulses the read strobe; callers read status before it, as software must
    task automatic pop();
        @(posedge mclk);
        #1 rd = 1'b1;
        @(posedge mclk);
        #1 rd = 1'b0;
    endtask
    task automatic wait_rx();
        for (int n = 0; n < 2000 && rxc !== 1'b1; n++) @(posedge mclk);
        #1;
    endtask
    function automatic logic par_of(input logic [8:0] d, input int nb, input logic odd);
        return (^(d & ((9'h001 << nb) - 9'h001))) ^ odd;
    endfunction

    // -----------------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; clk_en = 1'b1; rx_enable = 1'b1; irq_en = 1'b1; ds = 1'b0;
        pen = 1'b0; podd = 1'b0; sbs = 1'b0; csz = 3'h3; rd = 1'b0;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk(12'(rxc), 12'h000);
        chk(12'(ovr), 12'h001);
        for (int k = 0; k < 5; k++) begin
            csz = sz[k];
            m.send(9'h1B5, k + 5, 1'b0, 1'b0, 1'b1, 16);
            wait_rx();
            chk(head, {3'b000, 9'h1B5 & ((9'h001 << (k + 5)) - 9'h001)});
            chk(12'(irq), 12'h001);
            pop();
            chk(12'({rxc, irq}), 12'h000);
        end
        pen = 1'b1;
        for (int j = 0; j < 4; j++) begin
            podd = j[0];
            m.send(9'h1D3, 9, 1'b1, par_of(9'h1D3, 9, podd) ^ j[1], 1'b1, 16);
            wait_rx();
            chk(head, {1'b0, j[1], 1'b0, 9'h1D3});
            pen = 1'b0;
            @(posedge mclk);
            #1 chk(12'(pe), 12'h000);
            pen = 1'b1;
            pop();
        end
        pen = 1'b0; csz = 3'h3; sbs = 1'b1; irq_en = 1'b0;
        m.send(9'h05A, 8, 1'b0, 1'b0, 1'b0, 16);
        wait_rx();
        chk(head, {3'b001, 9'h05A});
        chk(12'(irq), 12'h000);
        pop();
        irq_en = 1'b1;
        m.hold(1'b0, 3);
        m.hold(1'b1, 32);
        chk(12'(rxc), 12'h000);
        ds = 1'b1;
        m.send(9'h03C, 8, 1'b0, 1'b0, 1'b1, 8);
        wait_rx();
        chk(head, {3'b000, 9'h03C});
        clk_en = 1'b0;
        pop();
        chk(12'(rxc), 12'h001);
        clk_en = 1'b1;
        pop();
        ds = 1'b0;
        for (int f = 1; f < 5; f++) m.send(9'(f * 17), 8, 1'b0, 1'b0, 1'b1, 16);
        chk(head, {3'b000, 9'h011});
        pop();
        chk(head, {3'b000, 9'h022});
        pop();
        chk(head, {3'b100, 9'h044});
        pop();
        chk(12'(rxc), 12'h000);
        m.send(9'h077, 8, 1'b0, 1'b0, 1'b1, 16);
        wait_rx();
        rx_enable = 1'b0;
        @(posedge mclk);
        #1 chk(12'({rxc, ovr}), 12'h000);
        rx_enable = 1'b1;
        fork
            m.send(9'h0FF, 8, 1'b0, 1'b0, 1'b1, 16);
            begin
                repeat (100) @(posedge mclk);
                #1 rx_enable = 1'b0;
                repeat (3) @(posedge mclk);
                #1 rx_enable = 1'b1;
            end
        join
        repeat (50) @(posedge mclk);
        #1 chk(12'(rxc), 12'h000);
        print_verdict();
    end
endmodule
